/* rtl/eswg_pkg.sv */
// shared constants and types for the signature and write guard block
// Overview of operation
// [RULE1] in deep power-down only signature command acts
// [RULE2] signature readable in standby, never while busy
// [RULE3] host sends opcode then 24 dummy bits
// [RULE4] signature shifts out after last dummy bit
// [RULE5] signature repeats until chip select rises
// [RULE6] chip select rise returns device to standby
// [RULE7] early rise still leaves power-down, after delay
// [RULE8] write enable latch cleared at power-up
// [RULE9] only write-enable instruction sets the latch
// [RULE10] completed byte/page/status write clears latch
// [RULE11] internal write starts only on exact count
// [RULE12] accesses ignored while internal write runs
// [RULE13] power-up in standby, deselected, latch clear
// [RULE14] serial output high-impedance at power-on
// [RULE15] only a chip select fall activates device
// [RULE16] power-down entered only on exact eighth bit
// [RULE17] opcodes and signature are implementation parameters
// [RULE18] drive output only while shifting signature out
`default_nettype none
package eswg_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // opcodes and signature, values arbitrary
    localparam logic [7:0]  OP_SIGNATURE    = 8'hC1; // see [RULE17]
    localparam logic [7:0]  OP_WRITE_ENABLE = 8'hC2;
    localparam logic [7:0]  OP_POWER_DOWN   = 8'hC3;
    localparam logic [7:0]  OP_ARRAY_WRITE  = 8'hC4;
    localparam logic [7:0]  OP_STATUS_WRITE = 8'hC5;
    localparam logic [7:0]  SIGNATURE_VALUE = 8'h5A; // see [RULE17]

    ////////////////////////////////////////////////////////////////////////////
    // bit counts of the serial frame
    localparam int          CNT_W           = 12;
    localparam logic [11:0] CNT_MAX         = 12'hFFF;
    localparam logic [11:0] OPCODE_BITS     = 12'h008;
    localparam logic [11:0] SIG_START_BITS  = 12'h020;
    localparam logic [11:0] STATUS_WR_BITS  = 12'h010;
    localparam logic [11:0] ARRAY_MIN_BITS  = 12'h028;

    ////////////////////////////////////////////////////////////////////////////
    // synchroniser reset levels, order {cs_n, sck, si}
    localparam logic [2:0]  SYNC_RST        = 3'h4;
    localparam int          SYNC_CS         = 2;
    localparam int          SYNC_SCK        = 1;
    localparam int          SYNC_SI         = 0;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int          TMR_W           = 16;
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          WRITE_TIME_NS   = 20000;
    localparam int          RELEASE_TIME_NS = 1000;
    localparam int          WRITE_CYCLES    = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RELEASE_CYCLES  =
        (RELEASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////
    // operating modes
    typedef enum logic [1:0] {
        MD_STANDBY,
        MD_POWER_DOWN,
        MD_RELEASE,
        MD_BUSY
    } eswg_mode_type;

endpackage
`default_nettype wire

/* rtl/eswg_sync.sv */
// two-stage synchroniser for the serial pins
`timescale 1ns/1ps
`default_nettype none
module eswg_sync (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // pins and synchronised levels
    input  wire logic [2:0] pin_i,
    output logic      [2:0] sync_o
);

    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] stable;
    } eswg_sync_type;

    eswg_sync_type st_ff;
    eswg_sync_type nxt_st;

    // first stage feeds only the second
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.meta   = pin_i;
        nxt_st.stable = st_ff.meta;
    end

    // reset levels look like an idle, deselected bus
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= {eswg_pkg::SYNC_RST, eswg_pkg::SYNC_RST};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_o = st_ff.stable;

endmodule
`default_nettype wire

/* rtl/eswg_timer.sv */
// one-shot cycle timer with a single-cycle done pulse
`timescale 1ns/1ps
`default_nettype none
module eswg_timer #(
    parameter logic [15:0] CYCLES = 16'h0001
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // control
    input  wire logic start_i,
    output logic      done_o
);

    typedef struct packed {
        logic        run;
        logic [15:0] left;
        logic        done;
    } eswg_timer_type;

    eswg_timer_type st_ff;
    eswg_timer_type nxt_st;

    // counts down from CYCLES; a start while running is not re-armed
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.done = 1'b0;
        if (start_i && !st_ff.run) begin
            nxt_st.run  = 1'b1;
            nxt_st.left = CYCLES;
        end else if (st_ff.run) begin
            if (st_ff.left <= 16'h0001) begin
                nxt_st.run  = 1'b0;
                nxt_st.done = 1'b1;
            end else begin
                nxt_st.left = st_ff.left - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign done_o = st_ff.done;

endmodule
`default_nettype wire

/* rtl/eswg_top.sv */
// serial command front end: signature read, power-down and write guard
`timescale 1ns/1ps
`default_nettype none
module eswg_top (
    // clock and reset
    input  wire logic CLOCK_I,
    input  wire logic RESETN_I,
    // serial link from the host
    input  wire logic SPI_CS_N_I,
    input  wire logic SPI_SCK_I,
    input  wire logic SPI_SI_I,
    output logic      SPI_SO_O,
    output logic      SPI_SO_OE_O,
    // device state
    output logic      WEL_O,
    output logic      BUSY_O,
    output logic      POWER_DOWN_O,
    output logic      WRITE_START_O
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        eswg_pkg::eswg_mode_type mode;
        logic                    cs_n_d;
        logic                    sck_d;
        logic                    selected;
        logic [11:0]             bit_cnt;
        logic [7:0]              shreg;
        logic [7:0]              opcode;
        logic                    op_valid;
        logic [2:0]              sig_idx;
        logic                    so;
        logic                    so_oe;
        logic                    wel;
        logic                    wr_start;
        logic                    rel_start;
    } eswg_state_type;

    eswg_state_type st_ff;
    eswg_state_type nxt_st;

    logic [2:0] pins_sync;
    logic       cs_n_s;
    logic       sck_s;
    logic       si_s;
    logic       cs_fall;
    logic       cs_rise;
    logic       sck_rise;
    logic       sck_fall;
    logic       wr_done;
    logic       rel_done;
    logic       sig_active;

    // opcode match, only once the full opcode has arrived
    function automatic logic op_is(input logic valid, input logic [7:0] op,
                                   input logic [7:0] code);
        op_is = valid && (op == code);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and timers

    eswg_sync u_sync (
        .clk_i   (CLOCK_I),
        .rst_n_i (RESETN_I),
        .pin_i   ({SPI_CS_N_I, SPI_SCK_I, SPI_SI_I}),
        .sync_o  (pins_sync)
    );

    eswg_timer #(
        .CYCLES (16'(eswg_pkg::WRITE_CYCLES))
    ) u_write_timer (
        .clk_i   (CLOCK_I),
        .rst_n_i (RESETN_I),
        .start_i (st_ff.wr_start),
        .done_o  (wr_done)
    );

    eswg_timer #(
        .CYCLES (16'(eswg_pkg::RELEASE_CYCLES))
    ) u_release_timer (
        .clk_i   (CLOCK_I),
        .rst_n_i (RESETN_I),
        .start_i (st_ff.rel_start),
        .done_o  (rel_done)
    );

    // edges found on the synchronised levels only
    assign cs_n_s   = pins_sync[eswg_pkg::SYNC_CS];
    assign sck_s    = pins_sync[eswg_pkg::SYNC_SCK];
    assign si_s     = pins_sync[eswg_pkg::SYNC_SI];
    assign cs_fall  = st_ff.cs_n_d && !cs_n_s;
    assign cs_rise  = !st_ff.cs_n_d && cs_n_s;
    assign sck_rise = !st_ff.sck_d && sck_s && st_ff.selected;
    assign sck_fall = st_ff.sck_d && !sck_s && st_ff.selected;

    // signature allowed in standby and power-down, never while busy
    assign sig_active = op_is(st_ff.op_valid, st_ff.opcode, eswg_pkg::OP_SIGNATURE) &&
                        ((st_ff.mode == eswg_pkg::MD_STANDBY) ||
                         (st_ff.mode == eswg_pkg::MD_POWER_DOWN)); // see [RULE1] [RULE2]

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nxt_st           = st_ff;
        nxt_st.cs_n_d    = cs_n_s;
        nxt_st.sck_d     = sck_s;
        nxt_st.wr_start  = 1'b0;
        nxt_st.rel_start = 1'b0;

        // a frame opens only on a falling chip select
        if (cs_fall) begin
            nxt_st.selected = 1'b1; // see [RULE15]
            nxt_st.bit_cnt  = '0;
            nxt_st.op_valid = 1'b0;
            nxt_st.sig_idx  = '0;
        end

        // sample input on rising clock; counter saturates on long frames
        if (sck_rise) begin
            nxt_st.shreg = {st_ff.shreg[6:0], si_s};
            if (st_ff.bit_cnt != eswg_pkg::CNT_MAX) begin
                nxt_st.bit_cnt = st_ff.bit_cnt + 12'h001;
            end
            if (st_ff.bit_cnt == eswg_pkg::OPCODE_BITS - 12'h001) begin
                nxt_st.opcode   = {st_ff.shreg[6:0], si_s};
                nxt_st.op_valid = 1'b1;
            end
        end

        // after the 24 dummy bits the signature goes out, wrapping forever
        if (sck_fall && sig_active && (st_ff.bit_cnt >= eswg_pkg::SIG_START_BITS)) begin
            nxt_st.so      = eswg_pkg::SIGNATURE_VALUE[3'h7 - st_ff.sig_idx]; // see [RULE4]
            nxt_st.so_oe   = 1'b1; // see [RULE18]
            nxt_st.sig_idx = st_ff.sig_idx + 3'h1; // see [RULE5]
        end

        // closing a frame decides what the command does
        if (cs_rise && st_ff.selected) begin
            nxt_st.selected = 1'b0;
            nxt_st.so_oe    = 1'b0; // see [RULE6]
            case (st_ff.mode)
                eswg_pkg::MD_POWER_DOWN: begin
                    // an early rise after the opcode still releases
                    if (op_is(st_ff.op_valid, st_ff.opcode, eswg_pkg::OP_SIGNATURE)) begin
                        nxt_st.mode      = eswg_pkg::MD_RELEASE; // see [RULE7]
                        nxt_st.rel_start = 1'b1;
                    end
                end
                eswg_pkg::MD_STANDBY: begin
                    if (op_is(st_ff.op_valid, st_ff.opcode, eswg_pkg::OP_WRITE_ENABLE) &&
                        (st_ff.bit_cnt == eswg_pkg::OPCODE_BITS)) begin
                        nxt_st.wel = 1'b1; // see [RULE9]
                    end
                    if (op_is(st_ff.op_valid, st_ff.opcode, eswg_pkg::OP_POWER_DOWN) &&
                        (st_ff.bit_cnt == eswg_pkg::OPCODE_BITS)) begin
                        nxt_st.mode = eswg_pkg::MD_POWER_DOWN; // see [RULE16]
                    end
                    // writes need the latch and a whole-byte count
                    if (st_ff.wel &&
                        ((op_is(st_ff.op_valid, st_ff.opcode, eswg_pkg::OP_STATUS_WRITE) &&
                          (st_ff.bit_cnt == eswg_pkg::STATUS_WR_BITS)) ||
                         (op_is(st_ff.op_valid, st_ff.opcode, eswg_pkg::OP_ARRAY_WRITE) &&
                          (st_ff.bit_cnt >= eswg_pkg::ARRAY_MIN_BITS) &&
                          (st_ff.bit_cnt[2:0] == 3'h0) &&
                          (st_ff.bit_cnt != eswg_pkg::CNT_MAX)))) begin
                        nxt_st.mode     = eswg_pkg::MD_BUSY; // see [RULE11]
                        nxt_st.wr_start = 1'b1;
                    end
                end
                default: begin
                    // busy or releasing: the frame is dropped
                    nxt_st.mode = st_ff.mode; // see [RULE12]
                end
            endcase
        end

        // write ends: latch falls so the next write needs a fresh enable
        if ((st_ff.mode == eswg_pkg::MD_BUSY) && wr_done) begin
            nxt_st.mode = eswg_pkg::MD_STANDBY;
            nxt_st.wel  = 1'b0; // see [RULE10]
        end
        if ((st_ff.mode == eswg_pkg::MD_RELEASE) && rel_done) begin
            nxt_st.mode = eswg_pkg::MD_STANDBY; // see [RULE7]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; reset means standby, deselected, latch clear, output off

    always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            st_ff        <= '0; // see [RULE8] [RULE13] [RULE14]
            st_ff.cs_n_d <= 1'b1;
            st_ff.mode   <= eswg_pkg::MD_STANDBY;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign SPI_SO_O      = st_ff.so;
    assign SPI_SO_OE_O   = st_ff.so_oe;
    assign WEL_O         = st_ff.wel;
    assign BUSY_O        = (st_ff.mode == eswg_pkg::MD_BUSY);
    assign POWER_DOWN_O  = (st_ff.mode == eswg_pkg::MD_POWER_DOWN);
    assign WRITE_START_O = st_ff.wr_start;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    property p_pd_ignores_enable;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        (st_ff.mode == eswg_pkg::MD_POWER_DOWN) && cs_rise && !st_ff.wel
        |=> !st_ff.wel && (st_ff.mode != eswg_pkg::MD_BUSY);
    endproperty
    a_pd_ignores_enable: assert property (p_pd_ignores_enable) // see [RULE1]
        else $error("command acted in power-down");

    property p_sig_first_bit;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        sck_fall && sig_active && (st_ff.bit_cnt == eswg_pkg::SIG_START_BITS) &&
        (st_ff.sig_idx == 3'h0) && !cs_rise
        |=> SPI_SO_OE_O && (SPI_SO_O == eswg_pkg::SIGNATURE_VALUE[7]);
    endproperty
    a_sig_first_bit: assert property (p_sig_first_bit) // see [RULE4]
        else $error("signature msb not driven after dummy bits");

    property p_no_output_busy;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        $rose(SPI_SO_OE_O) |-> $past(st_ff.mode) != eswg_pkg::MD_BUSY;
    endproperty
    a_no_output_busy: assert property (p_no_output_busy) // see [RULE2]
        else $error("output enabled during internal write");

    property p_oe_only_selected;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        SPI_SO_OE_O |-> st_ff.selected;
    endproperty
    a_oe_only_selected: assert property (p_oe_only_selected) // see [RULE18]
        else $error("output driven while deselected");

    property p_sig_wraps;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        sck_fall && SPI_SO_OE_O && sig_active && (st_ff.sig_idx == 3'h0) && !cs_rise
        |=> SPI_SO_O == eswg_pkg::SIGNATURE_VALUE[7];
    endproperty
    a_sig_wraps: assert property (p_sig_wraps) // see [RULE5]
        else $error("signature did not repeat");

    property p_wel_set;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        (st_ff.mode == eswg_pkg::MD_STANDBY) && cs_rise && st_ff.selected &&
        op_is(st_ff.op_valid, st_ff.opcode, eswg_pkg::OP_WRITE_ENABLE) &&
        (st_ff.bit_cnt == eswg_pkg::OPCODE_BITS)
        |=> WEL_O;
    endproperty
    a_wel_set: assert property (p_wel_set) // see [RULE9]
        else $error("write enable did not set latch");

    property p_wel_only_by_enable;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        $rose(WEL_O) |-> $past(st_ff.opcode) == eswg_pkg::OP_WRITE_ENABLE;
    endproperty
    a_wel_only_by_enable: assert property (p_wel_only_by_enable) // see [RULE9]
        else $error("latch set by other command");

    property p_done_clears_wel;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        BUSY_O && wr_done |=> !WEL_O && !BUSY_O;
    endproperty
    a_done_clears_wel: assert property (p_done_clears_wel) // see [RULE10]
        else $error("latch not cleared after write");

    property p_write_needs_bytes;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        WRITE_START_O |-> $past(st_ff.bit_cnt[2:0]) == 3'h0 && $past(st_ff.wel);
    endproperty
    a_write_needs_bytes: assert property (p_write_needs_bytes) // see [RULE11]
        else $error("write started on partial byte");

    property p_busy_holds;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        BUSY_O && !wr_done |=> BUSY_O;
    endproperty
    a_busy_holds: assert property (p_busy_holds) // see [RULE12]
        else $error("internal write cut short");

    property p_release_on_rise;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        POWER_DOWN_O && cs_rise && st_ff.selected &&
        op_is(st_ff.op_valid, st_ff.opcode, eswg_pkg::OP_SIGNATURE)
        |=> (st_ff.mode == eswg_pkg::MD_RELEASE) ##1
            (st_ff.mode == eswg_pkg::MD_RELEASE)[*3];
    endproperty
    a_release_on_rise: assert property (p_release_on_rise) // see [RULE7]
        else $error("power-down not released through delay");

    property p_pd_exact;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        $rose(POWER_DOWN_O) |-> $past(st_ff.bit_cnt) == eswg_pkg::OPCODE_BITS;
    endproperty
    a_pd_exact: assert property (p_pd_exact) // see [RULE16]
        else $error("power-down entered on wrong count");

    property p_reset_state;
        @(posedge CLOCK_I)
        !RESETN_I |-> !WEL_O && !SPI_SO_OE_O && !BUSY_O && !POWER_DOWN_O;
    endproperty
    a_reset_state: assert property (p_reset_state) // see [RULE8] [RULE13] [RULE14]
        else $error("wrong state during reset");

    property p_select_on_fall;
        @(posedge CLOCK_I) disable iff (!RESETN_I)
        $rose(st_ff.selected) |-> $past(cs_fall);
    endproperty
    a_select_on_fall: assert property (p_select_on_fall) // see [RULE15]
        else $error("selected without chip select fall");

    c_sig_read: cover property (@(posedge CLOCK_I) $rose(SPI_SO_OE_O));
    c_pd_enter: cover property (@(posedge CLOCK_I) $rose(POWER_DOWN_O));
    c_release:  cover property (@(posedge CLOCK_I) rel_done);
    c_write:    cover property (@(posedge CLOCK_I) wr_done);

endmodule
`default_nettype wire

/* sim/eswg_host_model.sv */
// host side serial controller model driving chip select, clock and data
`timescale 1ns/1ps
`default_nettype none
module eswg_host_model (
    // clock
    input  wire logic clk_i,
    // serial link to the device
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      si_o,
    input  wire logic so_i,
    input  wire logic so_oe_i
);

    ////////////////////////////////////////////////////////////////////////////
    // idle levels: deselected, clock parked low
    initial begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
        si_o   = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one mode 0 frame, tx left aligned; rx and oe hold what was seen at each rise
    // clock stands still between frames, so the device sees edges only inside them
    task automatic xfer(input logic [63:0] tx, input int nbits,
                        output logic [63:0] rx, output logic [63:0] oe);
        int i;
        rx = '0;
        oe = '0;
        @(negedge clk_i);
        cs_n_o = 1'b0;                       // every frame opens on a fall
        repeat (4) @(negedge clk_i);
        for (i = 0; i < nbits; i++) begin
            si_o = tx[63 - i];               // opcode then the rest of tx, msb first
            repeat (4) @(negedge clk_i);
            // no pull on the line: a released output shows the opposite level
            rx[63 - i] = so_oe_i ? so_i : ~so_i;
            oe[63 - i] = so_oe_i;
            sck_o      = 1'b1;
            repeat (4) @(negedge clk_i);
            sck_o = 1'b0;
        end
        repeat (4) @(negedge clk_i);
        // rise right after the last bit
        cs_n_o = 1'b1;
        si_o   = ~si_o;                      // released line shows no stale level
        repeat (8) @(negedge clk_i);
    endtask

endmodule
`default_nettype wire

/* sim/eswg_tb_top.sv */
// self-checking bench for the signature and write guard block
`timescale 1ns/1ps
`default_nettype none
module eswg_tb_top;

    ////////////////////////////////////////////////////////////////////////////
    // signals
    logic        clk;
    logic        rst_n;
    wire logic   cs_n;
    wire logic   sck;
    wire logic   si;
    wire logic   so;
    wire logic   so_oe;
    wire logic   wel;
    wire logic   busy;
    wire logic   pd;
    wire logic   wstart;
    int          bad_count;
    int          samples_checked;
    int          cycles;
    int          starts;
    logic [63:0] rx;
    logic [63:0] oe;

    eswg_top dut_u (
        .CLOCK_I       (clk),
        .RESETN_I      (rst_n),
        .SPI_CS_N_I    (cs_n),
        .SPI_SCK_I     (sck),
        .SPI_SI_I      (si),
        .SPI_SO_O      (so),
        .SPI_SO_OE_O   (so_oe),
        .WEL_O         (wel),
        .BUSY_O        (busy),
        .POWER_DOWN_O  (pd),
        .WRITE_START_O (wstart)
    );

    eswg_host_model host_u (
        .clk_i   (clk),
        .cs_n_o  (cs_n),
        .sck_o   (sck),
        .si_o    (si),
        .so_i    (so),
        .so_oe_i (so_oe)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock, hang guard and a count of accepted internal writes
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // the pulse stands one cycle, so it is counted rather than polled
    always @(negedge clk) begin
        cycles++;
        if (wstart === 1'b1) begin
            starts++;
        end
        if (cycles == 60000) begin
            bad_count++;
            $display("mismatch at %0t: run timed out", $time);
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask

    task automatic send(input logic [7:0] op, input int nbits);
        host_u.xfer({op, 56'hA5_0F00_3C96_5AC3}, nbits, rx, oe);
    endtask

    // full signature frame with two bytes clocked out after the dummy address
    task automatic sig_read(input logic ok);
        logic [31:0] exp_sig;
        exp_sig = 32'({2{eswg_pkg::SIGNATURE_VALUE}});
        host_u.xfer({eswg_pkg::OP_SIGNATURE, 56'h0}, 48, rx, oe);
        check(oe[63:32], 32'h0, "output before dummy address end");
        check(32'(oe[31:16]), ok ? 32'hFFFF : 32'h0, "oe during signature");
        if (ok) begin
            check(32'(rx[31:16]), exp_sig, "signature bytes");
        end
        check(32'(so_oe), 32'h0, "output still driven after deselect");
    endtask

    task automatic wait_idle();
        int n;
        for (n = 0; n < eswg_pkg::WRITE_CYCLES + 100 && busy !== 1'b0; n++) begin
            @(negedge clk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        check(32'({wel, busy, pd}), 32'h0, "latch or mode in reset");
        check(32'({so_oe, wstart}), 32'h0, "output in reset");
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        check(32'({wel, busy, pd}), 32'h0, "latch or mode after reset");
        check(32'({so_oe, wstart}), 32'h0, "output after reset");
    endtask

    task automatic t_standby_sig();
        sig_read(1'b1);
        check(32'(pd), 32'h0, "power-down after standby signature");
    endtask

    task automatic t_latch();
        send(eswg_pkg::OP_WRITE_ENABLE, 9);
        check(32'(wel), 32'h0, "latch set by a nine bit frame");
        send(eswg_pkg::OP_WRITE_ENABLE, 8);
        check(32'(wel), 32'h1, "latch not set by write enable");
        t_reset();
        check(32'(wel), 32'h0, "latch survived a reset");
    endtask

    task automatic t_writes();
        int s;
        s = starts;
        send(eswg_pkg::OP_ARRAY_WRITE, 40);
        check(32'(starts - s), 32'h0, "write started without latch");
        send(eswg_pkg::OP_WRITE_ENABLE, 8);
        send(eswg_pkg::OP_ARRAY_WRITE, 41);
        check(32'(starts - s), 32'h0, "write started on a ragged count");
        send(eswg_pkg::OP_ARRAY_WRITE, 40);
        check(32'(starts - s), 32'h1, "write not started on exact count");
        check(32'(busy), 32'h1, "not busy after write start");
        sig_read(1'b0);
        send(eswg_pkg::OP_ARRAY_WRITE, 48);
        check(32'(starts - s), 32'h1, "access accepted while busy");
        wait_idle();
        check(32'({busy, wel}), 32'h0, "busy or latch after array write");
        send(eswg_pkg::OP_WRITE_ENABLE, 8);
        send(eswg_pkg::OP_STATUS_WRITE, 16);
        check(32'(starts - s), 32'h2, "status write not started");
        wait_idle();
        check(32'({busy, wel}), 32'h0, "busy or latch after status write");
    endtask

    task automatic t_power_down();
        send(eswg_pkg::OP_POWER_DOWN, 9);
        check(32'(pd), 32'h0, "power-down on a nine bit frame");
        send(eswg_pkg::OP_POWER_DOWN, 8);
        check(32'(pd), 32'h1, "power-down not entered");
        send(eswg_pkg::OP_WRITE_ENABLE, 8);
        check(32'(wel), 32'h0, "write enable acted in power-down");
        sig_read(1'b1);
        check(32'(pd), 32'h0, "still powered down after signature");
        repeat (eswg_pkg::RELEASE_CYCLES + 20) @(negedge clk);
        send(eswg_pkg::OP_POWER_DOWN, 8);
        send(eswg_pkg::OP_SIGNATURE, 8);
        check(32'(pd), 32'h0, "early deselect left device powered down");
        send(eswg_pkg::OP_WRITE_ENABLE, 8);
        check(32'(wel), 32'h0, "command taken inside the release delay");
        repeat (eswg_pkg::RELEASE_CYCLES) @(negedge clk);
        send(eswg_pkg::OP_WRITE_ENABLE, 8);
        check(32'(wel), 32'h1, "standby not reached after release delay");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // verdict and main sequence
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        bad_count       = 0;
        samples_checked = 0;
        cycles          = 0;
        starts          = 0;
        t_reset();
        t_standby_sig();
        t_latch();
        t_writes();
        t_power_down();
        conclude();
    end

endmodule
`default_nettype wire
